/* shared/sasc_pkg.sv */
package sasc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// Longest times round down to whole cycles
	localparam int CONV_BYPASS_NS = 660;
	localparam int CONV_AMP_NS = 1550;
	localparam int BUSY_RISE_NS = 30;
	localparam int CONV_BYPASS_CYC = CONV_BYPASS_NS / CLK_PERIOD_NS;
	localparam int CONV_AMP_CYC = CONV_AMP_NS / CLK_PERIOD_NS;
	localparam int BUSY_RISE_CYC = BUSY_RISE_NS / CLK_PERIOD_NS;
	localparam int CONV_CNT_W = 8;

	localparam int CODE_W = 14;
	localparam int RAW_W = 16;
	localparam int TAG_W = 6;
	localparam int FRAME_W = CODE_W + TAG_W;
	localparam logic signed [CODE_W-1:0] CODE_MAX = 14'sh1fff;
	localparam logic signed [CODE_W-1:0] CODE_MIN = -14'sh2000;
	localparam int PAIR_COUNT = 8;
	localparam logic [2:0] PAIR_LAST = 3'h7;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RESULT = 8'h08;
	localparam int CTRL_HOLD_OFF_BIT = 0;
	localparam logic CTRL_RESET = 1'b0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LOW_POWER_BIT = 1;
	localparam int ST_BYPASS_BIT = 2;
	localparam int ST_SWEEP_LSB = 4;
	localparam int ST_CHAN_LSB = 8;
	localparam int ST_GAIN_LSB = 12;
	localparam int RES_CLAMP_BIT = 16;

	typedef struct packed {
		logic [2:0] chan;
		logic [2:0] gain;
	} sasc_sel_t;

	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_ARM = 2'b01,
		SW_RUN = 2'b10,
		SW_TAIL = 2'b11
	} sasc_sweep_t;
endpackage

/* rtl/sasc_sync.sv */
`timescale 1ns/1ps
module sasc_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] prev_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign q_o = sync_reg;
	assign rise_o = sync_reg & ~prev_reg;
	assign fall_o = ~sync_reg & prev_reg;
endmodule

/* rtl/sasc_clamp.sv */
`timescale 1ns/1ps
module sasc_clamp (
	input wire logic signed [sasc_pkg::RAW_W-1:0] raw_i,
	output logic signed [sasc_pkg::CODE_W-1:0] code_o,
	output logic clamped_o
);
	localparam logic signed [sasc_pkg::RAW_W-1:0] HI = sasc_pkg::RAW_W'(sasc_pkg::CODE_MAX);
	localparam logic signed [sasc_pkg::RAW_W-1:0] LO = sasc_pkg::RAW_W'(sasc_pkg::CODE_MIN);

	always_comb begin
		clamped_o = 1'b1;
		if (raw_i > HI) begin
			code_o = sasc_pkg::CODE_MAX;
		end else if (raw_i < LO) begin
			code_o = sasc_pkg::CODE_MIN;
		end else begin
			code_o = raw_i[sasc_pkg::CODE_W-1:0];
			clamped_o = 1'b0;
		end
	end
endmodule

/* rtl/sasc_top.sv */
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Low power: tracking lasts exactly while convert-start is held high.
// - Bypassed amplifier: busy rises within 30ns of convert-start falling.
// - Bypassed amplifier: conversion completes within 660ns.
// - Channel and gain pins are captured on each convert-start rise.
// - Normal mode: selections captured on sample n apply on sample n+1.
// - Low power: captured selections apply to the very next conversion.
// - Amplifier is bypassed or set to gain 1,2,3,4,6,8,12,16.
// - Output code saturates between -8192 and 8191.
// - Sweep steps pairs 0 to 7 and wraps while sweep stays high.
// - Normal sweep: first sample initializes, second ignored, pair 0 at second fall.
// - Each later convert-start rise advances the sweep to the next pair.
// - Low power sweep: first sample ignored, pair 0 at second fall.
// - In sweep the tag reports the sequencer channel, not the pins.
// - After sweep drops one more sequencer pair, then the pins choose.
// - Tag shifts channel bits then gain bits, each most significant first.
// - Convert-start fall starts a conversion; output floats while it is high.
// - Busy stays high for the conversion; result MSB present when it drops.
// - Low power select high picks low power mode, else normal.
// - Amplifier bypass high makes the gain selection ignored.
module sasc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic convert_start_n_i,
	input wire logic serial_clk_i,
	input wire logic [2:0] chan_sel_i,
	input wire logic [2:0] gain_sel_i,
	input wire logic sweep_i,
	input wire logic low_power_select_i,
	input wire logic amp_bypass_i,
	input wire logic signed [sasc_pkg::RAW_W-1:0] raw_code_i,
	output logic serial_result_out_o,
	output logic serial_result_out_oe_o,
	output logic busy_o,
	output logic track_o,
	output logic [2:0] active_chan_o,
	output logic amp_bypass_o,
	output logic [4:0] amp_gain_factor_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	logic [1:0] edge_q;
	logic [1:0] edge_rise;
	logic [1:0] edge_fall;
	logic [8:0] lvl_q;
	logic cs_high;
	logic cs_rise;
	logic cs_fall;
	logic sck_rise;
	sasc_pkg::sasc_sel_t pins;
	logic sweep_s;
	logic low_power;
	logic bypass_s;

	sasc_sync #(.W(2)) u_edge_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({serial_clk_i, convert_start_n_i}),
		.q_o(edge_q),
		.rise_o(edge_rise),
		.fall_o(edge_fall)
	);

	sasc_sync #(.W(9)) u_level_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({amp_bypass_i, low_power_select_i, sweep_i, chan_sel_i, gain_sel_i}),
		.q_o(lvl_q),
		.rise_o(),
		.fall_o()
	);

	// Reset value of zero matches the idle low pin, so no false start follows reset
	assign cs_high = edge_q[0];
	assign cs_rise = edge_rise[0];
	assign cs_fall = edge_fall[0];
	assign sck_rise = edge_rise[1];
	assign pins = lvl_q[5:0];
	assign sweep_s = lvl_q[6];
	assign low_power = lvl_q[7];
	assign bypass_s = lvl_q[8];

	logic hold_off_reg;
	logic busy_reg;
	logic start_ok;
	assign start_ok = cs_fall && !hold_off_reg;

	// Selection capture: latch holds sample n, prev holds sample n-1
	sasc_pkg::sasc_sel_t latch_reg;
	sasc_pkg::sasc_sel_t prev_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_reg <= '0;
			prev_reg <= '0;
		end else if (cs_rise) begin
			prev_reg <= latch_reg;
			latch_reg <= pins;
		end
	end

	// Sweep sequencer
	sasc_pkg::sasc_sweep_t sweep_reg;
	logic [2:0] seq_reg;
	logic use_seq_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sweep_reg <= sasc_pkg::SW_IDLE;
			seq_reg <= '0;
			use_seq_reg <= 1'b0;
		end else if (cs_rise) begin
			case (sweep_reg)
				sasc_pkg::SW_IDLE: begin
					seq_reg <= '0;
					use_seq_reg <= sweep_s;
					if (sweep_s) begin
						sweep_reg <= sasc_pkg::SW_ARM;
					end
				end
				sasc_pkg::SW_ARM: begin
					use_seq_reg <= sweep_s;
					sweep_reg <= sweep_s ? sasc_pkg::SW_RUN : sasc_pkg::SW_IDLE;
				end
				sasc_pkg::SW_RUN: begin
					// Wraps naturally from the last pair to pair 0
					seq_reg <= seq_reg + 3'h1;
					use_seq_reg <= 1'b1;
					sweep_reg <= sweep_s ? sasc_pkg::SW_RUN : sasc_pkg::SW_TAIL;
				end
				sasc_pkg::SW_TAIL: begin
					seq_reg <= '0;
					use_seq_reg <= sweep_s;
					sweep_reg <= sweep_s ? sasc_pkg::SW_ARM : sasc_pkg::SW_IDLE;
				end
				default: begin
					sweep_reg <= sasc_pkg::SW_IDLE;
					seq_reg <= '0;
					use_seq_reg <= 1'b0;
				end
			endcase
		end
	end

	// Selections applied at the sampling instant
	logic [2:0] act_chan_reg;
	logic [2:0] act_gain_reg;
	logic act_bypass_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_chan_reg <= '0;
			act_gain_reg <= '0;
			act_bypass_reg <= 1'b0;
		end else if (start_ok) begin
			if (use_seq_reg) begin
				act_chan_reg <= seq_reg;
			end else begin
				act_chan_reg <= low_power ? latch_reg.chan : prev_reg.chan;
			end
			act_gain_reg <= low_power ? latch_reg.gain : prev_reg.gain;
			act_bypass_reg <= bypass_s;
		end
	end

	function automatic logic [4:0] gain_factor(input logic [2:0] code);
		logic [4:0] f;
		f = 5'h01;
		case (code)
			3'h0: f = 5'h01;
			3'h1: f = 5'h02;
			3'h2: f = 5'h03;
			3'h3: f = 5'h04;
			3'h4: f = 5'h06;
			3'h5: f = 5'h08;
			3'h6: f = 5'h0c;
			3'h7: f = 5'h10;
			default: f = 5'h01;
		endcase
		return f;
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			amp_gain_factor_o <= '0;
			amp_bypass_o <= 1'b0;
		end else begin
			amp_bypass_o <= act_bypass_reg;
			// Zero factor means bypassed; gain pins have no effect then
			amp_gain_factor_o <= act_bypass_reg ? 5'h00 : gain_factor(act_gain_reg);
		end
	end

	// Conversion timing
	logic [sasc_pkg::CONV_CNT_W-1:0] conv_cnt_reg;
	logic [sasc_pkg::CONV_CNT_W-1:0] conv_limit;
	logic conv_done;
	assign conv_limit = act_bypass_reg ? sasc_pkg::CONV_CNT_W'(sasc_pkg::CONV_BYPASS_CYC)
		: sasc_pkg::CONV_CNT_W'(sasc_pkg::CONV_AMP_CYC);
	assign conv_done = busy_reg && (conv_cnt_reg == conv_limit - 8'h01);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_reg <= 1'b0;
			conv_cnt_reg <= '0;
		end else if (start_ok) begin
			busy_reg <= 1'b1;
			conv_cnt_reg <= '0;
		end else if (conv_done) begin
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			conv_cnt_reg <= conv_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			track_o <= 1'b0;
		end else begin
			track_o <= cs_high && !busy_reg;
		end
	end

	// Result, clamp and serial frame
	logic signed [sasc_pkg::CODE_W-1:0] clamp_code;
	logic clamp_hit;
	logic signed [sasc_pkg::CODE_W-1:0] result_reg;
	logic clamp_reg;
	logic [sasc_pkg::FRAME_W-1:0] frame_reg;

	sasc_clamp u_clamp (
		.raw_i(raw_code_i),
		.code_o(clamp_code),
		.clamped_o(clamp_hit)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_reg <= '0;
			clamp_reg <= 1'b0;
		end else if (conv_done) begin
			result_reg <= clamp_code;
			clamp_reg <= clamp_hit;
		end
	end

	// Frame shifts only after busy drops; output is low during conversion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_reg <= '0;
		end else if (start_ok) begin
			frame_reg <= '0;
		end else if (conv_done) begin
			frame_reg <= {clamp_code, act_chan_reg, act_gain_reg};
		end else if (sck_rise && !busy_reg && !cs_high) begin
			frame_reg <= {frame_reg[sasc_pkg::FRAME_W-2:0], 1'b0};
		end
	end

	assign serial_result_out_o = frame_reg[sasc_pkg::FRAME_W-1];
	assign serial_result_out_oe_o = !cs_high;
	assign busy_o = busy_reg;
	assign active_chan_o = act_chan_reg;

	// Wishbone slave, one wait state, unmapped reads return zero
	logic [31:0] rd_data;
	always_comb begin
		rd_data = '0;
		case (wb_adr_i)
			sasc_pkg::REG_CTRL: rd_data[sasc_pkg::CTRL_HOLD_OFF_BIT] = hold_off_reg;
			sasc_pkg::REG_STATUS: begin
				rd_data[sasc_pkg::ST_BUSY_BIT] = busy_reg;
				rd_data[sasc_pkg::ST_LOW_POWER_BIT] = low_power;
				rd_data[sasc_pkg::ST_BYPASS_BIT] = act_bypass_reg;
				rd_data[sasc_pkg::ST_SWEEP_LSB +: 2] = sweep_reg;
				rd_data[sasc_pkg::ST_CHAN_LSB +: 3] = act_chan_reg;
				rd_data[sasc_pkg::ST_GAIN_LSB +: 3] = act_gain_reg;
			end
			sasc_pkg::REG_RESULT: begin
				rd_data[sasc_pkg::CODE_W-1:0] = result_reg;
				rd_data[sasc_pkg::RES_CLAMP_BIT] = clamp_reg;
			end
			default: rd_data = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= rd_data;
			end
		end
	end

	// Hold-off lets software stop new conversions without touching the pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_off_reg <= sasc_pkg::CTRL_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == sasc_pkg::REG_CTRL) begin
			hold_off_reg <= wb_dat_i[sasc_pkg::CTRL_HOLD_OFF_BIT];
		end
	end

	sequence s_frame_loaded;
		$fell(busy_reg) ##0 (serial_result_out_o == result_reg[sasc_pkg::CODE_W-1]);
	endsequence

	property p_busy_rise;
		@(posedge clk_i) disable iff (rst_i) start_ok |=> busy_reg;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy not raised after start");

	property p_conv_bypass;
		@(posedge clk_i) disable iff (rst_i) ($rose(busy_reg) && act_bypass_reg) |-> ##[1:66] !busy_reg;
	endproperty
	a_conv_bypass: assert property (p_conv_bypass) else $error("bypassed conversion too long");

	property p_float_high;
		@(posedge clk_i) disable iff (rst_i) cs_high |-> !serial_result_out_oe_o;
	endproperty
	a_float_high: assert property (p_float_high) else $error("output driven while start high");

	property p_msb_ready;
		@(posedge clk_i) disable iff (rst_i) $fell(busy_reg) |-> s_frame_loaded;
	endproperty
	a_msb_ready: assert property (p_msb_ready) else $error("result msb missing at busy fall");

	property p_clamp_hi;
		@(posedge clk_i) disable iff (rst_i)
			($past(conv_done) && $past(raw_code_i) > 16'sh1fff) |-> result_reg == sasc_pkg::CODE_MAX;
	endproperty
	a_clamp_hi: assert property (p_clamp_hi) else $error("high code not clamped");

	property p_lp_apply;
		@(posedge clk_i) disable iff (rst_i) (start_ok && low_power && !use_seq_reg) |=>
			act_chan_reg == $past(latch_reg.chan) && act_gain_reg == $past(latch_reg.gain);
	endproperty
	a_lp_apply: assert property (p_lp_apply) else $error("low power selection not applied");

	property p_nm_delay;
		@(posedge clk_i) disable iff (rst_i) (start_ok && !low_power) |=> act_gain_reg == $past(prev_reg.gain);
	endproperty
	a_nm_delay: assert property (p_nm_delay) else $error("normal gain not delayed");

	property p_wrap;
		@(posedge clk_i) disable iff (rst_i) (cs_rise && sweep_reg == sasc_pkg::SW_RUN && seq_reg == 3'h7)
			|=> seq_reg == 3'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("sweep did not wrap");

	property p_idle_zero;
		@(posedge clk_i) disable iff (rst_i) (sweep_reg == sasc_pkg::SW_IDLE && $past(cs_rise)) |-> seq_reg == 3'h0;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("counter not cleared when idle");

	property p_seq_tag;
		@(posedge clk_i) disable iff (rst_i) (start_ok && use_seq_reg) |=> act_chan_reg == $past(seq_reg);
	endproperty
	a_seq_tag: assert property (p_seq_tag) else $error("tag not from sequencer");

	property p_shift;
		@(posedge clk_i) disable iff (rst_i) (sck_rise && !busy_reg && !cs_high && !start_ok && !conv_done)
			|=> serial_result_out_o == $past(frame_reg[sasc_pkg::FRAME_W-2]);
	endproperty
	a_shift: assert property (p_shift) else $error("serial shift order wrong");

	property p_bypass_gain;
		@(posedge clk_i) disable iff (rst_i) $past(act_bypass_reg) |-> amp_gain_factor_o == 5'h00;
	endproperty
	a_bypass_gain: assert property (p_bypass_gain) else $error("gain applied while bypassed");
endmodule

/* dv/sasc_host.sv */
`timescale 1ns/1ps
module sasc_host (
	input wire logic clk_i,
	input wire logic busy_i,
	input wire logic sdo_i,
	input wire logic oe_i,
	input wire logic track_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic [2:0] chan_o,
	output logic [2:0] gain_o
);
	// 160ns serial clock, held low outside frames
	localparam int HALF_SCK = 8;
	initial begin
		cs_n_o = 1'b0;
		sck_o = 1'b0;
		chan_o = 3'h0;
		gain_o = 3'h0;
	end
	task automatic sample(input logic [2:0] c, input logic [2:0] g, output logic [19:0] frame,
		output int dly, output int blen, output logic oe_hi, output logic trk_hi);
		frame = '0;
		dly = 0;
		blen = 0;
		@(posedge clk_i);
		// Selects change only between conversions
		chan_o <= c;
		gain_o <= g;
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		repeat (60) @(posedge clk_i);
		@(negedge clk_i);
		oe_hi = oe_i;
		trk_hi = track_i;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		do begin
			@(negedge clk_i);
			dly++;
		end while (busy_i !== 1'b1 && dly < 300);
		while (busy_i === 1'b1 && blen < 400) begin
			blen++;
			@(negedge clk_i);
		end
		frame[19] = sdo_i;
		// Result then tag: twenty bits in all
		for (int n = 18; n >= 0; n--) begin
			@(posedge clk_i);
			sck_o <= 1'b1;
			repeat (HALF_SCK) @(posedge clk_i);
			sck_o <= 1'b0;
			repeat (HALF_SCK - 1) @(posedge clk_i);
			@(negedge clk_i);
			frame[n] = sdo_i;
		end
	endtask
endmodule

/* dv/tb_sasc_top.sv */
`timescale 1ns/1ps
module tb_sasc_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sweep = 1'b0;
	logic lps = 1'b0;
	logic byp = 1'b1;
	logic signed [15:0] raw = '0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = '0;
	logic [31:0] wdat = '0;
	logic cs_n, sck, serial_result_out, oe, busy, ack, oe_hi, trk, track, abyp;
	logic [2:0] chan, gain, achan;
	logic [4:0] gfac;
	logic [31:0] rdat, q;
	logic [19:0] fr;
	int dly, blen, err_total, n_checks, ticks;
	localparam logic [4:0] GTAB [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10};

	always #5 clk_i = ~clk_i;

	sasc_top uut (.clk_i(clk_i), .rst_i(rst_i), .convert_start_n_i(cs_n), .serial_clk_i(sck),
		.chan_sel_i(chan), .gain_sel_i(gain), .sweep_i(sweep), .low_power_select_i(lps),
		.amp_bypass_i(byp), .raw_code_i(raw), .serial_result_out_o(serial_result_out), .serial_result_out_oe_o(oe),
		.busy_o(busy), .track_o(track), .active_chan_o(achan), .amp_bypass_o(abyp), .amp_gain_factor_o(gfac),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

	sasc_host host (.clk_i(clk_i), .busy_i(busy), .sdo_i(serial_result_out), .oe_i(oe), .track_i(track), .cs_n_o(cs_n),
		.sck_o(sck), .chan_o(chan), .gain_o(gain));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		check("wb ack", {31'h0, n < 20}, 32'h1);
	endtask

	task automatic conv(input logic [2:0] c, input logic [2:0] g, input logic signed [15:0] r);
		@(posedge clk_i);
		raw <= r;
		host.sample(c, g, fr, dly, blen, oe_hi, trk);
		check("float", {31'h0, oe_hi}, 32'h0);
		check("track high", {31'h0, trk}, 32'h1);
		check("track low", {31'h0, track}, 32'h0);
		check("bypass out", {31'h0, abyp}, {31'h0, byp});
		check("busy rise", {31'h0, dly <= 5}, 32'h1);
		check("busy len", 32'(blen), 32'(byp ? sasc_pkg::CONV_BYPASS_CYC : sasc_pkg::CONV_AMP_CYC));
	endtask

	task automatic t_bypass();
		logic signed [15:0] rv [5] = '{16'sh0064, 16'sh7fff, 16'sh8000, 16'sh2000, 16'she000};
		logic [13:0] ev [5] = '{14'h0064, 14'h1fff, 14'h2000, 14'h1fff, 14'h2000};
		@(posedge clk_i);
		lps <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			conv(3'(i), 3'(7 - i), rv[i]);
			check("code", {18'h0, fr[19:6]}, {18'h0, ev[i]});
			check("tag chan", {29'h0, fr[5:3]}, 32'(i));
			check("tag gain", {29'h0, fr[2:0]}, 32'(7 - i));
			check("chan", {29'h0, achan}, 32'(i));
			check("gain off", {27'h0, gfac}, 32'h0);
			wb(1'b0, sasc_pkg::REG_RESULT, 32'h0);
			check("result", q & 32'h13fff, {15'h0, i >= 1 && i <= 3, 2'h0, ev[i]});
		end
		$display("t_bypass done");
	endtask

	task automatic t_amp();
		@(posedge clk_i);
		byp <= 1'b0;
		wb(1'b0, sasc_pkg::REG_STATUS, 32'h0);
		check("status lp", {31'h0, q[sasc_pkg::ST_LOW_POWER_BIT]}, 32'h1);
		for (int g = 0; g < 8; g++) begin
			conv(3'h1, 3'(g), 16'sh0000);
			check("gain", {27'h0, gfac}, {27'h0, GTAB[g]});
		end
		$display("t_amp done");
	endtask

	task automatic t_normal();
		@(posedge clk_i);
		lps <= 1'b0;
		byp <= 1'b1;
		conv(3'h2, 3'h0, 16'sh0000);
		conv(3'h6, 3'h0, 16'sh0000);
		check("chan late", {29'h0, achan}, 32'h2);
		conv(3'h1, 3'h0, 16'sh0000);
		check("chan late", {29'h0, achan}, 32'h6);
		$display("t_normal done");
	endtask

	task automatic t_sweep();
		@(posedge clk_i);
		lps <= 1'b1;
		sweep <= 1'b1;
		conv(3'h5, 3'h2, 16'sh0000);
		for (int k = 0; k < 10; k++) begin
			conv(3'h5, 3'h2, 16'sh0000);
			check("sweep tag", {29'h0, fr[5:3]}, 32'(k % 8));
		end
		@(posedge clk_i);
		sweep <= 1'b0;
		conv(3'h5, 3'h2, 16'sh0000);
		check("tail", {29'h0, achan}, 32'h2);
		conv(3'h5, 3'h2, 16'sh0000);
		check("pins", {29'h0, achan}, 32'h5);
		@(posedge clk_i);
		sweep <= 1'b1;
		conv(3'h3, 3'h2, 16'sh0000);
		conv(3'h3, 3'h2, 16'sh0000);
		check("restart", {29'h0, fr[5:3]}, 32'h0);
		@(posedge clk_i);
		sweep <= 1'b0;
		$display("t_sweep done");
	endtask

	task automatic t_regs();
		wb(1'b1, sasc_pkg::REG_CTRL, 32'h1);
		wb(1'b0, sasc_pkg::REG_CTRL, 32'h0);
		check("ctrl", q & 32'h1, 32'h1);
		// Hold-off must swallow the start edge: busy never rises
		host.sample(3'h0, 3'h0, fr, dly, blen, oe_hi, trk);
		check("held off", 32'(blen), 32'h0);
		wb(1'b0, sasc_pkg::REG_STATUS, 32'h0);
		check("held busy", q & 32'h1, 32'h0);
		wb(1'b1, sasc_pkg::REG_CTRL, 32'h0);
		wb(1'b0, 8'h10, 32'h0);
		check("unmapped", q, 32'h0);
		$display("t_regs done");
	endtask

	// Whole run needs about 15000 cycles
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 60000) begin
			err_total++;
			print_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check("busy idle", {31'h0, busy}, 32'h0);
		check("oe idle", {31'h0, oe}, 32'h1);
		t_bypass();
		t_amp();
		t_normal();
		t_sweep();
		t_regs();
		print_verdict();
	end
endmodule
